// *** rtl/uart_rx_format.sv ***
// receive framing, line format and baud divisor registers of a serial port
// assumes AXI4-Lite master on clk, receive line synchronous to clk
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "uart_rx_fmt_defs.svh"

// Notes on behaviour
// - parity even when select set, else odd
// - two stop checked when select set
// - queue on buffers, else single holding
// - word length field selects five to eight
// - stick with even expects parity zero
// - stick with odd expects parity one
// - oversample select zero gives sixteen ticks
// - oversample select one gives eight ticks
// - sixteen bit whole part in low bits
// - six bit fraction field resets zero
// - empty flag follows holding or queue
module uart_rx_format (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        rxLine,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             irq
);

	uart_rx_fmt_pkg::state_s s_reg;
	uart_rx_fmt_pkg::state_s s_next;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] wordBits(input logic [1:0] wl);
		return 4'(wl) + 4'h5;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic        tickHit;
	logic [4:0]  ovsTicks;
	logic [4:0]  midTick;
	logic        charDone;
	logic        expParity;
	logic [7:0]  dataAligned;
	logic        wrGo;
	logic        rdGo;
	logic [31:0] wr;
	logic        popData;
	logic        queueOn;
	logic [3:0]  events;

	always_comb begin
		s_next = s_reg;
		charDone = 1'b0;
		events = 4'h0;
		queueOn = s_reg.format[`FMT_QUEUE_ON];
		s_next.rxd = rxLine;
		ovsTicks = s_reg.ovsAct ? `OVS_FAST : `OVS_NORMAL;
		midTick = ovsTicks >> 1;
		// baud tick: divisor whole part plus fractional carry
		tickHit = 1'b0;
		if (s_reg.state == uart_rx_fmt_pkg::IDLE) begin
			s_next.baudCnt = 16'h0000;
			s_next.fracAcc = 7'h00;
			s_next.tick = 5'h00;
		end else if (s_reg.baudCnt + 16'h0001 >= s_reg.divIntAct + 16'(s_reg.fracAcc[6])) begin
			s_next.baudCnt = 16'h0000;
			s_next.fracAcc = {1'b0, s_reg.fracAcc[5:0]} + {1'b0, s_reg.divFracAct};
			tickHit = 1'b1;
		end else begin
			s_next.baudCnt = s_reg.baudCnt + 16'h0001;
		end
		expParity = s_reg.format[`FMT_STICK] ? ~s_reg.format[`FMT_EVEN_SELECT]
			: (^s_reg.shift) ^ ~s_reg.format[`FMT_EVEN_SELECT];
		dataAligned = s_reg.shift >> (4'h8 - wordBits(s_reg.format[`FMT_WLEN_HI:`FMT_WLEN_LO]));
		if (tickHit) begin
			s_next.tick = (s_reg.tick + 5'h01 == ovsTicks) ? 5'h00 : s_reg.tick + 5'h01;
		end
		case (s_reg.state)
			uart_rx_fmt_pkg::IDLE: begin
				s_next.parityBad = 1'b0;
				s_next.frameBad = 1'b0;
				s_next.shift = 8'h00;
				if (!s_reg.rxd) begin
					s_next.state = uart_rx_fmt_pkg::START;
				end
			end
			uart_rx_fmt_pkg::START: begin
				if (tickHit && s_reg.tick == midTick - 5'h01) begin
					s_next.tick = 5'h00;
					s_next.bitIdx = 3'h0;
					s_next.state = s_reg.rxd ? uart_rx_fmt_pkg::IDLE : uart_rx_fmt_pkg::DATA;
				end
			end
			uart_rx_fmt_pkg::DATA: begin
				if (tickHit && s_reg.tick == ovsTicks - 5'h01) begin
					s_next.shift = {s_reg.rxd, s_reg.shift[7:1]};
					s_next.bitIdx = s_reg.bitIdx + 3'h1;
					if (4'(s_reg.bitIdx) + 4'h1 == wordBits(s_reg.format[`FMT_WLEN_HI:`FMT_WLEN_LO])) begin
						s_next.state = s_reg.format[`FMT_PARITY_ON] ? uart_rx_fmt_pkg::PARITY : uart_rx_fmt_pkg::STOP1;
					end
				end
			end
			uart_rx_fmt_pkg::PARITY: begin
				if (tickHit && s_reg.tick == ovsTicks - 5'h01) begin
					s_next.parityBad = (s_reg.rxd != expParity);
					s_next.state = uart_rx_fmt_pkg::STOP1;
				end
			end
			uart_rx_fmt_pkg::STOP1: begin
				if (tickHit && s_reg.tick == ovsTicks - 5'h01) begin
					s_next.frameBad = ~s_reg.rxd;
					if (s_reg.format[`FMT_TWO_STOP]) begin
						s_next.state = uart_rx_fmt_pkg::STOP2;
					end else begin
						charDone = 1'b1;
						s_next.state = uart_rx_fmt_pkg::IDLE;
					end
				end
			end
			uart_rx_fmt_pkg::STOP2: begin
				if (tickHit && s_reg.tick == ovsTicks - 5'h01) begin
					s_next.frameBad = s_reg.frameBad | ~s_reg.rxd;
					charDone = 1'b1;
					s_next.state = uart_rx_fmt_pkg::IDLE;
				end
			end
			default: begin
				s_next.state = uart_rx_fmt_pkg::IDLE;
			end
		endcase
		// divisor takes effect only between characters
		if (s_reg.state == uart_rx_fmt_pkg::IDLE) begin
			s_next.divIntAct = s_reg.divisor_whole_part;
			s_next.divFracAct = s_reg.divisor_fraction_part;
			s_next.ovsAct = s_reg.oversample;
		end
		// ----------------------------------------
		// bus read
		// ----------------------------------------
		rdGo = arvalid && s_reg.arready;
		popData = 1'b0;
		s_next.arready = 1'b0;
		if (s_reg.rvalid && rready) begin
			s_next.rvalid = 1'b0;
		end
		if (!s_reg.rvalid && !s_reg.arready && !s_next.rvalid && arvalid) begin
			s_next.arready = 1'b1;
		end
		if (rdGo) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = `AXI_RESP_OKAY;
			s_next.rdata = 32'h0000_0000;
			if (araddr == `ADDR_RX_FORMAT) begin
				s_next.rdata = s_reg.format;
			end else if (araddr == `ADDR_DIV_INT) begin
				s_next.rdata = {16'h0000, s_reg.divisor_whole_part};
			end else if (araddr == `ADDR_DIV_FRAC) begin
				s_next.rdata = {26'h000_0000, s_reg.divisor_fraction_part};
			end else if (araddr == `ADDR_CTRL) begin
				s_next.rdata = {31'h0000_0000, s_reg.oversample};
			end else if (araddr == `ADDR_STATUS) begin
				s_next.rdata = {30'h0000_0000, (queueOn ? s_reg.count == `FIFO_CNT_W'(`FIFO_DEPTH) : !s_reg.empty),
					s_reg.empty};
			end else if (araddr == `ADDR_IRQ_STATUS) begin
				s_next.rdata = {28'h000_0000, s_reg.irqStatus};
			end else if (araddr == `ADDR_IRQ_ENABLE) begin
				s_next.rdata = {28'h000_0000, s_reg.irqEnable};
			end else if (araddr == `ADDR_RX_DATA) begin
				s_next.rdata = queueOn ? {22'h00_0000, s_reg.fifoMem[s_reg.rdPtr]} : {24'h00_0000, s_reg.hold};
				popData = !s_reg.empty;
			end else begin
				s_next.rresp = `AXI_RESP_SLVERR;
			end
		end
		// ----------------------------------------
		// bus write
		// ----------------------------------------
		s_next.awready = 1'b0;
		s_next.wready = 1'b0;
		if (awvalid && s_reg.awready) begin
			s_next.awvalidTaken = 1'b1;
			s_next.awaddr = awaddr;
		end
		if (wvalid && s_reg.wready) begin
			s_next.wvalidTaken = 1'b1;
			s_next.wdata = wdata;
			s_next.wstrb = wstrb;
		end
		if (!s_reg.bvalid && !s_next.awvalidTaken && !s_reg.awready && awvalid) begin
			s_next.awready = 1'b1;
		end
		if (!s_reg.bvalid && !s_next.wvalidTaken && !s_reg.wready && wvalid) begin
			s_next.wready = 1'b1;
		end
		if (s_reg.bvalid && bready) begin
			s_next.bvalid = 1'b0;
		end
		wrGo = s_reg.awvalidTaken && s_reg.wvalidTaken && !s_reg.bvalid;
		if (wrGo) begin
			s_next.awvalidTaken = 1'b0;
			s_next.wvalidTaken = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = `AXI_RESP_OKAY;
			if (s_reg.awaddr == `ADDR_RX_FORMAT) begin
				wr = merge(s_reg.format, s_reg.wdata, s_reg.wstrb);
				s_next.format = wr & `FMT_MASK;
			end else if (s_reg.awaddr == `ADDR_DIV_INT) begin
				wr = merge({16'h0000, s_reg.divisor_whole_part}, s_reg.wdata, s_reg.wstrb);
				s_next.divisor_whole_part = wr[15:0];
			end else if (s_reg.awaddr == `ADDR_DIV_FRAC) begin
				wr = merge({26'h000_0000, s_reg.divisor_fraction_part}, s_reg.wdata, s_reg.wstrb);
				s_next.divisor_fraction_part = wr[5:0];
			end else if (s_reg.awaddr == `ADDR_CTRL) begin
				wr = merge({31'h0000_0000, s_reg.oversample}, s_reg.wdata, s_reg.wstrb);
				s_next.oversample = wr[`CTRL_OVERSAMPLE];
			end else if (s_reg.awaddr == `ADDR_IRQ_ENABLE) begin
				wr = merge({28'h000_0000, s_reg.irqEnable}, s_reg.wdata, s_reg.wstrb);
				s_next.irqEnable = wr[3:0];
			end else if (s_reg.awaddr == `ADDR_IRQ_CLEAR) begin
				wr = merge(32'h0000_0000, s_reg.wdata, s_reg.wstrb);
				s_next.irqStatus = s_reg.irqStatus & ~wr[3:0];
			end else begin
				wr = 32'h0000_0000;
				s_next.bresp = `AXI_RESP_SLVERR;
			end
		end else begin
			wr = 32'h0000_0000;
		end
		// ----------------------------------------
		// receive storage
		// ----------------------------------------
		if (popData) begin
			if (queueOn) begin
				s_next.rdPtr = s_reg.rdPtr + `FIFO_PTR_W'(1);
				s_next.count = s_reg.count - `FIFO_CNT_W'(1);
				s_next.empty = (s_reg.count == `FIFO_CNT_W'(1));
			end else begin
				s_next.empty = 1'b1;
			end
		end
		if (charDone) begin
			events[`IRQ_RECEIVED] = 1'b1;
			events[`IRQ_PARITY_ERR] = s_next.parityBad;
			events[`IRQ_FRAME_ERR] = s_next.frameBad;
			if (queueOn) begin
				if (s_next.count == `FIFO_CNT_W'(`FIFO_DEPTH)) begin
					events[`IRQ_OVERRUN] = 1'b1;
				end else begin
					s_next.fifoMem[s_reg.wrPtr] = {s_next.frameBad, s_next.parityBad, dataAligned};
					s_next.wrPtr = s_reg.wrPtr + `FIFO_PTR_W'(1);
					s_next.count = s_next.count + `FIFO_CNT_W'(1);
					s_next.empty = 1'b0;
				end
			end else begin
				events[`IRQ_OVERRUN] = !s_next.empty;
				s_next.hold = dataAligned;
				s_next.empty = 1'b0;
			end
		end
		// set wins over clear
		s_next.irqStatus = s_next.irqStatus | events;
		s_next.irq = |(s_next.irqStatus & s_next.irqEnable);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
			s_reg.empty <= 1'b1;
			s_reg.rxd <= 1'b1;
			s_reg.state <= uart_rx_fmt_pkg::IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign awready = s_reg.awready;
	assign wready = s_reg.wready;
	assign bvalid = s_reg.bvalid;
	assign bresp = s_reg.bresp;
	assign arready = s_reg.arready;
	assign rvalid = s_reg.rvalid;
	assign rdata = s_reg.rdata;
	assign rresp = s_reg.rresp;
	assign irq = s_reg.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_divisor_hold_frame: assert property (s_reg.state != uart_rx_fmt_pkg::IDLE ##1 s_reg.state != uart_rx_fmt_pkg::IDLE |-> $stable(s_reg.divIntAct) && $stable(s_reg.divFracAct)) else $error("divisor changed mid frame");
	chk_divisor_load_idle: assert property (s_reg.state == uart_rx_fmt_pkg::IDLE |=> s_reg.divIntAct == $past(s_reg.divisor_whole_part)) else $error("divisor not loaded");
	chk_fraction_width: assert property (s_reg.divisor_fraction_part == (s_reg.divisor_fraction_part & 6'h3F) && (s_reg.format & ~`FMT_MASK) == 32'h0000_0000) else $error("bad field");
	chk_tick_range: assert property (s_reg.ovsAct |-> s_reg.tick < `OVS_FAST) else $error("tick over eight");
	chk_tick_normal: assert property (!s_reg.ovsAct && s_reg.state != uart_rx_fmt_pkg::IDLE |-> s_reg.tick < `OVS_NORMAL) else $error("tick over sixteen");
	chk_parity_skip: assert property (s_reg.state == uart_rx_fmt_pkg::DATA && !s_reg.format[`FMT_PARITY_ON] |=> s_reg.state != uart_rx_fmt_pkg::PARITY) else $error("parity without enable");
	chk_stop_two: assert property (s_reg.state == uart_rx_fmt_pkg::STOP1 && !s_reg.format[`FMT_TWO_STOP] |=> s_reg.state != uart_rx_fmt_pkg::STOP2) else $error("extra stop");
	chk_empty_clear: assert property (charDone && !(queueOn && s_reg.count == `FIFO_CNT_W'(`FIFO_DEPTH)) |=> !s_reg.empty) else $error("empty after char");
	chk_irq_level: assert property (##1 s_reg.irq == $past(|(s_next.irqStatus & s_next.irqEnable))) else $error("irq mismatch");
	chk_bits_count: assert property (s_reg.state == uart_rx_fmt_pkg::DATA |-> 4'(s_reg.bitIdx) < wordBits(s_reg.format[`FMT_WLEN_HI:`FMT_WLEN_LO])) else $error("too many bits");

	cov_frame_done: cover property (charDone);
	cov_parity_err: cover property (charDone && s_next.parityBad);
	cov_queue_full: cover property (s_reg.count == `FIFO_CNT_W'(`FIFO_DEPTH));
	cov_stick_check: cover property (s_reg.state == uart_rx_fmt_pkg::PARITY && s_reg.format[`FMT_STICK]);

endmodule // uart_rx_format

// *** rtl/uart_rx_fmt_defs.svh ***
// constants for the receive format and baud divisor block
// assumes inclusion by the package and the design file
`ifndef UART_RX_FMT_DEFS_SVH
`define UART_RX_FMT_DEFS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_RX_FORMAT      8'h1C
`define ADDR_DIV_INT        8'h24
`define ADDR_DIV_FRAC       8'h28
`define ADDR_CTRL           8'h30
`define ADDR_STATUS         8'h34
`define ADDR_IRQ_STATUS     8'h38
`define ADDR_IRQ_ENABLE     8'h3C
`define ADDR_IRQ_CLEAR      8'h40
`define ADDR_RX_DATA        8'h44

// ----------------------------------------
// field positions
// ----------------------------------------
`define FMT_PARITY_ON       1
`define FMT_EVEN_SELECT     2
`define FMT_TWO_STOP        3
`define FMT_QUEUE_ON        4
`define FMT_WLEN_LO         5
`define FMT_WLEN_HI         6
`define FMT_STICK           7
`define FMT_MASK            32'h0000_00FE
`define DIV_INT_MASK        32'h0000_FFFF
`define DIV_FRAC_MASK       32'h0000_003F
`define CTRL_OVERSAMPLE     0
`define STAT_EMPTY          0
`define STAT_FULL           1
`define IRQ_RECEIVED        0
`define IRQ_PARITY_ERR      1
`define IRQ_FRAME_ERR       2
`define IRQ_OVERRUN         3

// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define OVS_NORMAL          5'h10
`define OVS_FAST            5'h08
`define FIFO_DEPTH          8
`define FIFO_PTR_W          3
`define FIFO_CNT_W          4
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// *** rtl/uart_rx_fmt_pkg.sv ***
// types for the receive format and baud divisor block
// assumes the defines header for sizes
`include "uart_rx_fmt_defs.svh"

package uart_rx_fmt_pkg;

	typedef enum logic [2:0] {
		IDLE,
		START,
		DATA,
		PARITY,
		STOP1,
		STOP2
	} rx_state_e;

	typedef struct packed {
		logic [31:0]                  format;
		logic [15:0]                  divisor_whole_part;
		logic [5:0]                   divisor_fraction_part;
		logic [15:0]                  divIntAct;
		logic [5:0]                   divFracAct;
		logic                         oversample;
		logic                         ovsAct;
		logic [3:0]                   irqStatus;
		logic [3:0]                   irqEnable;
		logic                         irq;
		rx_state_e                    state;
		logic [15:0]                  baudCnt;
		logic [6:0]                   fracAcc;
		logic [4:0]                   tick;
		logic [2:0]                   bitIdx;
		logic [7:0]                   shift;
		logic                         parityBad;
		logic                         frameBad;
		logic [7:0]                   hold;
		logic [`FIFO_DEPTH-1:0][9:0]  fifoMem;
		logic [`FIFO_PTR_W-1:0]       wrPtr;
		logic [`FIFO_PTR_W-1:0]       rdPtr;
		logic [`FIFO_CNT_W-1:0]       count;
		logic                         empty;
		logic                         awvalidTaken;
		logic                         wvalidTaken;
		logic [7:0]                   awaddr;
		logic [31:0]                  wdata;
		logic [3:0]                   wstrb;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		logic                         rxd;
	} state_s;

endpackage

// *** sim/serial_sender.sv ***
// remote serial sender model driving the receive line
// assumes the bench calls send from one process at a time
`timescale 1ns/100ps

module serial_sender (
	input  wire logic clk,
	output logic      rxLine
);
	initial rxLine = 1'b1;

	// ----------
	// frame out
	// ----------
	// first bit first; last bit cut short, the line idles high after it
	task automatic send(input int bitLen, input logic [11:0] frame, input int nBits);
		for (int i = 0; i < nBits; i++) begin
			@(posedge clk);
			rxLine <= frame[i];
			repeat ((i == nBits - 1) ? bitLen * 5 / 8 : bitLen - 1) @(posedge clk);
		end
		@(posedge clk);
		rxLine <= 1'b1;
	endtask
endmodule // serial_sender

// *** sim/test_uart_rx_format.sv ***
// self-checking bench for the receive format and baud divisor block
// assumes the design and the serial sender model are compiled first
`timescale 1ns/100ps
`include "uart_rx_fmt_defs.svh"

module test_uart_rx_format;
	typedef struct {
		logic [7:0] fmt;
		logic       ovs;
		logic [7:0] data;
		logic       flip;
		logic       badStop;
	} row_s;

	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	wire         rxLine;
	logic [7:0]  awaddr = 8'h0;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rdv;
	int          errorCnt = 0;
	int          testsRun = 0;
	logic [7:0]  regAddr [4] = '{`ADDR_RX_FORMAT, `ADDR_DIV_INT, `ADDR_DIV_FRAC, `ADDR_CTRL};
	logic [31:0] regMask [4] = '{`FMT_MASK, `DIV_INT_MASK, `DIV_FRAC_MASK, 32'h1};
	row_s        rows [11] = '{
		'{8'h70, 1'b0, 8'hA5, 1'b0, 1'b0},
		'{8'h00, 1'b0, 8'hF5, 1'b0, 1'b0},
		'{8'h36, 1'b0, 8'h2B, 1'b0, 1'b0},
		'{8'h52, 1'b1, 8'hDC, 1'b0, 1'b0},
		'{8'h76, 1'b0, 8'h3C, 1'b1, 1'b0},
		'{8'hF6, 1'b0, 8'h83, 1'b0, 1'b0},
		'{8'hF2, 1'b0, 8'h83, 1'b0, 1'b0},
		'{8'hF2, 1'b0, 8'h01, 1'b1, 1'b0},
		'{8'h78, 1'b0, 8'hC3, 1'b0, 1'b0},
		'{8'h78, 1'b0, 8'h3E, 1'b0, 1'b1},
		'{8'h74, 1'b1, 8'h07, 1'b0, 1'b0}
	};

	always #50 clk = ~clk;

	uart_rx_format u_uart_rx_format (
		.clk(clk), .arst_n(arst_n), .rxLine(rxLine),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq)
	);

	serial_sender u_serial_sender (
		.clk(clk),
		.rxLine(rxLine)
	);

	// ----------
	// helpers
	// ----------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			errorCnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		if (errorCnt == 0 && testsRun > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic awDone;
		logic wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge clk);
			if (!awDone && awready === 1'b1) begin
				awDone = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wDone && wready === 1'b1) begin
				wDone = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rdv = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// builds start, data lsb first, parity, stops and sends them
	task automatic frame(input logic [7:0] f, input logic [7:0] d, input logic flip, input logic bad, input int bitLen);
		logic [11:0] fr;
		logic [7:0]  dm;
		int          n;
		dm = d & (8'hFF >> (2'd3 - f[6:5]));
		fr = 12'hFFF;
		fr[0] = 1'b0;
		n = 1;
		for (int i = 0; i < 5 + f[6:5]; i++) begin
			fr[n] = dm[i];
			n++;
		end
		if (f[1]) begin
			fr[n] = (f[7] ? ~f[2] : (f[2] ? ^dm : ~^dm)) ^ flip;
			n++;
		end
		n += f[3] ? 2 : 1;
		fr[n - 1] = ~bad;
		u_serial_sender.send(bitLen, fr, n);
		repeat (2 * bitLen) @(posedge clk);
	endtask

	initial begin
		#(100 * 40000);
		errorCnt++;
		$display("[ERR] %0t watchdog expired", $time);
		results;
	end

	// ----------
	// main sequence
	// ----------
	initial begin
		row_s       r;
		logic [7:0] dm;
		logic       pe;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rd(`ADDR_STATUS);
		check(rdv, 32'h1);
		foreach (regAddr[k]) begin
			rd(regAddr[k]);
			check(rdv, 32'h0);
			wr(regAddr[k], 32'hFFFF_FFFF);
			rd(regAddr[k]);
			check(rdv, regMask[k]);
		end
		wr(8'h50, 32'h1);
		check({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
		rd(8'h50);
		check({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
		check(rdv, 32'h0);
		wr(`ADDR_DIV_INT, 32'h2);
		wr(`ADDR_DIV_FRAC, 32'h0);
		wr(`ADDR_IRQ_ENABLE, 32'h1);
		foreach (rows[k]) begin
			r = rows[k];
			dm = r.data & (8'hFF >> (2'd3 - r.fmt[6:5]));
			pe = r.fmt[1] & r.flip;
			wr(`ADDR_RX_FORMAT, {24'h0, r.fmt});
			wr(`ADDR_CTRL, {31'h0, r.ovs});
			frame(r.fmt, r.data, r.flip, r.badStop, r.ovs ? 16 : 32);
			check({31'h0, irq}, 32'h1);
			rd(`ADDR_STATUS);
			check({31'h0, rdv[0]}, 32'h0);
			rd(`ADDR_IRQ_STATUS);
			check(rdv, {28'h0, 1'b0, r.badStop, pe, 1'b1});
			rd(`ADDR_RX_DATA);
			check(r.fmt[4] ? rdv : {24'h0, rdv[7:0]}, r.fmt[4] ? {22'h0, r.badStop, pe, dm} : {24'h0, dm});
			rd(`ADDR_STATUS);
			check(rdv, 32'h1);
			wr(`ADDR_IRQ_CLEAR, 32'hF);
			repeat (2) @(posedge clk);
			check({31'h0, irq}, 32'h0);
		end
		// masked event, then enabled late
		wr(`ADDR_IRQ_ENABLE, 32'h0);
		wr(`ADDR_RX_FORMAT, 32'h70);
		wr(`ADDR_CTRL, 32'h0);
		frame(8'h70, 8'h5A, 1'b0, 1'b0, 32);
		check({31'h0, irq}, 32'h0);
		wr(`ADDR_IRQ_ENABLE, 32'h1);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		rd(`ADDR_RX_DATA);
		wr(`ADDR_IRQ_CLEAR, 32'hF);
		// divisor written mid-frame, two chars queued
		fork
			begin
				frame(8'h70, 8'h11, 1'b0, 1'b0, 32);
				frame(8'h70, 8'h22, 1'b0, 1'b0, 48);
			end
			begin
				repeat (150) @(posedge clk);
				wr(`ADDR_DIV_INT, 32'h3);
			end
		join
		rd(`ADDR_RX_DATA);
		check(rdv, 32'h11);
		rd(`ADDR_RX_DATA);
		check(rdv, 32'h22);
		rd(`ADDR_STATUS);
		check(rdv, 32'h1);
		// second reset in mid-run
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd(`ADDR_RX_FORMAT);
		check(rdv, 32'h0);
		rd(`ADDR_DIV_INT);
		check(rdv, 32'h0);
		results;
	end
endmodule // test_uart_rx_format
